// File: logic/mode_sink_bank.sv
// APB register bank: sink selects, operating mode, timer/counter, trim and general registers
// Overview of operation
// [R1] each first-port sink bit picks normal or high sink for its pin
// [R2] each second-port sink bit picks normal or high sink, bit 7 to pin 7
// [R3] mode register bits 7 and 3..0 always read zero
// [R4] mode bit 6 picks timer clock: 0 sub clock, 1 main clock
// [R5] mode bit 5 picks core clock: 1 main, 0 sub and main stopped
// [R6] on sleep instruction, mode bit 4 picks sleep (0) or idle (1)
// [R7] bank 2 addresses 9..F ignore writes and read zero
// [R8] timer counts external pin edges or instruction cycle ticks; with mode bit 6 at 0 it counts sub clock ticks instead
// [R9] external timer pulses must last longer than one instruction cycle
// [R10] timer option bit 5 chooses increment source and bit 4 the edge
// [R11] timer/counter register reads and writes like any register
// [R12] trim register holds fields only on emulator, else reads zero; production keeps the reset fields, unwritable, on rc_cfg
// [R13] trim field resets to 1111, nominal frequency
// [R14] range field resets to 11, the 4 MHz setting
// [R15] width bit: 0 accepts 8 fc pulses, 1 accepts 32 (default)
// [R16] external interrupt fires on falling edge through the filter
// [R17] filter bypassed in second slow crystal mode and during sleep
// [R18] filter enable resets to 1; off in low-frequency crystal mode
// [R19] undervoltage field selects reset threshold, 11 is power-on only
// [R20] bank 3 addresses 8..F read zero
// [R21] R10..R1F and per-bank R20..R3F are plain 8-bit registers
// [R22] sleep stops oscillator and timer, clears but keeps watchdog running
//
// Added by the designer: the APB interface to the registers.
`default_nettype none
module mode_sink_bank #(
	parameter bit EMULATOR = 1'b0
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleep_instruction,
	input wire logic wake_event,
	input wire logic instr_cycle_tick,
	input wire logic sub_clock_tick,
	input wire logic timer_pin,
	input wire logic ext_int_pin,
	input wire logic low_freq_crystal_mode,
	input wire logic slow_crystal_mode_two,
	output logic [7:0] port5_sink_control,
	output logic [7:0] port6_sink_control,
	output logic timer_clock_source_bit,
	output logic core_clock_select,
	output logic main_osc_run,
	output logic cpu_idle,
	output logic cpu_sleep,
	output logic watchdog_clear,
	output logic ext_int_event,
	output mode_sink_pkg::rc_cfg_t rc_cfg,
	output mode_sink_pkg::noise_uv_cfg_t noise_uv_cfg
);
	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	logic [1:0] bank;
	logic [5:0] idx;
	mode_sink_pkg::reg_sel_t sel;
	logic [7:0] gp_index;
	logic wr_en;
	logic wr_byte;

	function automatic mode_sink_pkg::reg_sel_t decode(input logic [1:0] b, input logic [5:0] i);
		mode_sink_pkg::reg_sel_t s;
		s = mode_sink_pkg::SEL_NONE;
		if (i >= mode_sink_pkg::IDX_GP_COMMON_FIRST) begin
			s = mode_sink_pkg::SEL_GP; // see [R21]
		end else if (b == mode_sink_pkg::BANK_OPTION && i == mode_sink_pkg::IDX_TIMER_OPTION) begin
			s = mode_sink_pkg::SEL_OPT;
		end else if (b == mode_sink_pkg::BANK_SINK_MODE) begin
			case (i)
				mode_sink_pkg::IDX_P5_SINK: s = mode_sink_pkg::SEL_P5;
				mode_sink_pkg::IDX_P6_SINK: s = mode_sink_pkg::SEL_P6;
				mode_sink_pkg::IDX_OP_MODE: s = mode_sink_pkg::SEL_MODE;
				default: begin
					if (i > mode_sink_pkg::IDX_OP_MODE) begin
						s = mode_sink_pkg::SEL_ZERO; // see [R7]
					end
				end
			endcase
		end else if (b == mode_sink_pkg::BANK_TIMER_TRIM) begin
			case (i)
				mode_sink_pkg::IDX_TIMER_COUNT: s = mode_sink_pkg::SEL_TIMER;
				mode_sink_pkg::IDX_RC_TRIM: s = mode_sink_pkg::SEL_RC;
				mode_sink_pkg::IDX_NOISE_UV: s = mode_sink_pkg::SEL_NOISE;
				default: begin
					if (i >= mode_sink_pkg::IDX_OP_MODE) begin
						s = mode_sink_pkg::SEL_ZERO; // see [R20]
					end
				end
			endcase
		end
		return s;
	endfunction

	assign bank = paddr[mode_sink_pkg::ADDR_BANK_LSB +: 2];
	assign idx = paddr[mode_sink_pkg::ADDR_IDX_LSB +: 6];
	assign sel = decode(bank, idx);
	assign gp_index = (idx < mode_sink_pkg::IDX_GP_BANK_FIRST)
		? {4'h0, idx[3:0]}
		: 8'(mode_sink_pkg::GP_COMMON_WORDS) + {1'b0, bank, idx[4:0]};
	assign wr_en = psel && penable && pwrite && (paddr[11:10] == 2'h0);
	assign wr_byte = wr_en && pstrb[0];

	// ------------------------------------------------------------
	// APB answer: zero wait states, error on unmapped words
	// ------------------------------------------------------------
	assign pready = 1'b1;
	assign pslverr = psel && penable
		&& (sel == mode_sink_pkg::SEL_NONE || paddr[11:10] != 2'h0);

	// ------------------------------------------------------------
	// port sink selects
	// ------------------------------------------------------------
	logic [7:0] p5_sink_reg;
	logic [7:0] p6_sink_reg;

	always_ff @(posedge mclk) begin
		if (srst) begin
			p5_sink_reg <= mode_sink_pkg::SINK_RESET;
			p6_sink_reg <= mode_sink_pkg::SINK_RESET;
		end else if (wr_byte) begin
			if (sel == mode_sink_pkg::SEL_P5) begin
				p5_sink_reg <= pwdata[7:0]; // see [R1]
			end
			if (sel == mode_sink_pkg::SEL_P6) begin
				p6_sink_reg <= pwdata[7:0]; // see [R2]
			end
		end
	end

	assign port5_sink_control = p5_sink_reg;
	assign port6_sink_control = p6_sink_reg;

	// ------------------------------------------------------------
	// operating mode and timer option
	// ------------------------------------------------------------
	logic [7:0] mode_reg;
	logic [7:0] opt_reg;

	always_ff @(posedge mclk) begin
		if (srst) begin
			mode_reg <= mode_sink_pkg::MODE_RESET;
			opt_reg <= mode_sink_pkg::OPT_RESET;
		end else if (wr_byte) begin
			if (sel == mode_sink_pkg::SEL_MODE) begin
				mode_reg <= pwdata[7:0] & mode_sink_pkg::MODE_WRITE_MASK; // see [R3]
			end
			if (sel == mode_sink_pkg::SEL_OPT) begin
				opt_reg <= pwdata[7:0] & mode_sink_pkg::OPT_WRITE_MASK;
			end
		end
	end

	assign timer_clock_source_bit = mode_reg[mode_sink_pkg::MODE_TIMER_SRC_BIT]; // see [R4]
	assign core_clock_select = mode_reg[mode_sink_pkg::MODE_CPU_CLK_BIT];

	// ------------------------------------------------------------
	// low-power state
	// ------------------------------------------------------------
	mode_sink_pkg::pwr_state_t pwr_reg;
	mode_sink_pkg::pwr_state_t pwr_next;

	always_comb begin
		pwr_next = pwr_reg;
		case (pwr_reg)
			mode_sink_pkg::PWR_RUN: begin
				if (sleep_instruction) begin
					pwr_next = mode_reg[mode_sink_pkg::MODE_IDLE_BIT]
						? mode_sink_pkg::PWR_IDLE : mode_sink_pkg::PWR_SLEEP; // see [R6]
				end
			end
			mode_sink_pkg::PWR_IDLE, mode_sink_pkg::PWR_SLEEP: begin
				if (wake_event) begin
					pwr_next = mode_sink_pkg::PWR_RUN;
				end
			end
			default: pwr_next = mode_sink_pkg::PWR_RUN;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			pwr_reg <= mode_sink_pkg::PWR_RUN;
			watchdog_clear <= 1'b0;
		end else begin
			pwr_reg <= pwr_next;
			watchdog_clear <= (pwr_next == mode_sink_pkg::PWR_SLEEP)
				&& (pwr_reg != mode_sink_pkg::PWR_SLEEP); // see [R22]
		end
	end

	assign cpu_idle = (pwr_reg == mode_sink_pkg::PWR_IDLE);
	assign cpu_sleep = (pwr_reg == mode_sink_pkg::PWR_SLEEP);
	assign main_osc_run = core_clock_select && !cpu_sleep; // see [R5] see [R22]

	// ------------------------------------------------------------
	// timer pin synchroniser and edge detect
	// ------------------------------------------------------------
	logic tpin1_reg;
	logic tpin2_reg;
	logic tpin3_reg;
	logic tpin_level_reg;
	logic tpin_rise;
	logic tpin_fall;

	always_ff @(posedge mclk) begin
		if (srst) begin
			tpin1_reg <= 1'b0;
			tpin2_reg <= 1'b0;
			tpin3_reg <= 1'b0;
			tpin_level_reg <= 1'b0;
		end else begin
			tpin1_reg <= timer_pin;
			tpin2_reg <= tpin1_reg;
			tpin3_reg <= tpin2_reg;
			if (tpin2_reg == tpin3_reg) begin
				tpin_level_reg <= tpin3_reg;
			end
		end
	end

	// a pin level shorter than one instruction cycle may be missed
	assign tpin_rise = (tpin2_reg == tpin3_reg) && tpin3_reg && !tpin_level_reg; // see [R9]
	assign tpin_fall = (tpin2_reg == tpin3_reg) && !tpin3_reg && tpin_level_reg;

	// ------------------------------------------------------------
	// timer/counter
	// ------------------------------------------------------------
	logic [7:0] timer_reg;
	logic timer_inc;
	logic internal_tick;

	assign internal_tick = timer_clock_source_bit ? instr_cycle_tick : sub_clock_tick;
	assign timer_inc = !cpu_sleep && (opt_reg[mode_sink_pkg::OPT_EXT_SRC_BIT] // see [R10]
		? (opt_reg[mode_sink_pkg::OPT_FALL_EDGE_BIT] ? tpin_fall : tpin_rise)
		: internal_tick); // see [R8] see [R22]

	always_ff @(posedge mclk) begin
		if (srst) begin
			timer_reg <= mode_sink_pkg::TIMER_RESET;
		end else if (wr_byte && sel == mode_sink_pkg::SEL_TIMER) begin
			timer_reg <= pwdata[7:0]; // see [R11]
		end else if (timer_inc) begin
			timer_reg <= timer_reg + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// emulator-only trim, noise and undervoltage fields
	// ------------------------------------------------------------
	logic [7:0] rc_reg;
	logic [7:0] noise_reg;

	always_ff @(posedge mclk) begin
		if (srst) begin
			rc_reg <= {mode_sink_pkg::RC_TRIM_RESET, mode_sink_pkg::RC_RANGE_RESET, 2'b00};
			noise_reg <= {2'b00, mode_sink_pkg::PKG_TYPE_RESET, mode_sink_pkg::NOISE_WIDE_RESET,
				mode_sink_pkg::NOISE_EN_RESET, mode_sink_pkg::UV_SEL_RESET}; // see [R18]
		end else if (wr_byte && EMULATOR) begin
			if (sel == mode_sink_pkg::SEL_RC) begin
				rc_reg <= pwdata[7:0] & mode_sink_pkg::RC_WRITE_MASK; // see [R13] see [R14]
			end
			if (sel == mode_sink_pkg::SEL_NOISE) begin
				noise_reg <= pwdata[7:0] & mode_sink_pkg::NOISE_UV_WRITE_MASK; // see [R19]
			end
		end
	end

	assign rc_cfg = rc_reg[7:2];
	assign noise_uv_cfg = noise_reg[5:0];

	// ------------------------------------------------------------
	// external interrupt noise rejection
	// ------------------------------------------------------------
	logic filter_on;

	assign filter_on = noise_uv_cfg.enable && !low_freq_crystal_mode // see [R18]
		&& !slow_crystal_mode_two && !cpu_sleep; // see [R17]

	int_noise_filter u_filter (
		.mclk(mclk),
		.srst(srst),
		.int_pin(ext_int_pin),
		.filter_on(filter_on),
		.wide(noise_uv_cfg.wide),
		.fall_pulse(ext_int_event)
	);

	// ------------------------------------------------------------
	// general-purpose registers
	// ------------------------------------------------------------
	logic [7:0] gp_mem [mode_sink_pkg::GP_TOTAL_WORDS];

	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int k = 0; k < mode_sink_pkg::GP_TOTAL_WORDS; k++) begin
				gp_mem[k] <= 8'h00;
			end
		end else if (wr_byte && sel == mode_sink_pkg::SEL_GP) begin
			gp_mem[gp_index] <= pwdata[7:0]; // see [R21]
		end
	end

	// ------------------------------------------------------------
	// read data, captured in the setup cycle
	// ------------------------------------------------------------
	logic [7:0] rd_byte;

	always_comb begin
		case (sel)
			mode_sink_pkg::SEL_P5: rd_byte = p5_sink_reg;
			mode_sink_pkg::SEL_P6: rd_byte = p6_sink_reg;
			mode_sink_pkg::SEL_MODE: rd_byte = mode_reg; // see [R3]
			mode_sink_pkg::SEL_OPT: rd_byte = opt_reg;
			mode_sink_pkg::SEL_TIMER: rd_byte = timer_reg; // see [R11]
			mode_sink_pkg::SEL_RC: rd_byte = EMULATOR ? rc_reg : 8'h00; // see [R12]
			mode_sink_pkg::SEL_NOISE: rd_byte = EMULATOR ? noise_reg : 8'h00;
			mode_sink_pkg::SEL_GP: rd_byte = gp_mem[gp_index];
			default: rd_byte = 8'h00; // see [R7] see [R20]
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			prdata <= (paddr[11:10] == 2'h0) ? {24'h000000, rd_byte} : 32'h00000000;
		end
	end
endmodule
`default_nettype wire

// File: inc/mode_sink_pkg.sv
// package: register map, field layout, reset values and types of the mode/sink/trim bank
`default_nettype none
package mode_sink_pkg;
	// ------------------------------------------------------------
	// register indices (byte address = 4 * index, index = {bank, reg})
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_TIMER_OPTION = 6'h03;
	localparam logic [5:0] IDX_TIMER_COUNT = 6'h05;
	localparam logic [5:0] IDX_P5_SINK = 6'h06;
	localparam logic [5:0] IDX_RC_TRIM = 6'h06;
	localparam logic [5:0] IDX_P6_SINK = 6'h07;
	localparam logic [5:0] IDX_NOISE_UV = 6'h07;
	localparam logic [5:0] IDX_OP_MODE = 6'h08;
	localparam logic [5:0] IDX_RSVD_LAST = 6'h0F;
	localparam logic [5:0] IDX_GP_COMMON_FIRST = 6'h10;
	localparam logic [5:0] IDX_GP_BANK_FIRST = 6'h20;
	localparam logic [1:0] BANK_OPTION = 2'h0;
	localparam logic [1:0] BANK_SINK_MODE = 2'h2;
	localparam logic [1:0] BANK_TIMER_TRIM = 2'h3;
	localparam int GP_COMMON_WORDS = 16;
	localparam int GP_BANK_WORDS = 32;
	localparam int GP_TOTAL_WORDS = 144;
	localparam int ADDR_BANK_LSB = 8;
	localparam int ADDR_IDX_LSB = 2;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int MODE_TIMER_SRC_BIT = 6;
	localparam int MODE_CPU_CLK_BIT = 5;
	localparam int MODE_IDLE_BIT = 4;
	localparam logic [7:0] MODE_WRITE_MASK = 8'h70;
	localparam int OPT_EXT_SRC_BIT = 5;
	localparam int OPT_FALL_EDGE_BIT = 4;
	localparam logic [7:0] OPT_WRITE_MASK = 8'h30;
	localparam logic [7:0] RC_WRITE_MASK = 8'hFC;
	localparam logic [7:0] NOISE_UV_WRITE_MASK = 8'h3F;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] SINK_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h20;
	localparam logic [7:0] OPT_RESET = 8'h00;
	localparam logic [7:0] TIMER_RESET = 8'h00;
	localparam logic [3:0] RC_TRIM_RESET = 4'hF;
	localparam logic [1:0] RC_RANGE_RESET = 2'h3;
	localparam logic [1:0] PKG_TYPE_RESET = 2'h0;
	localparam logic NOISE_WIDE_RESET = 1'b1;
	localparam logic NOISE_EN_RESET = 1'b1;
	localparam logic [1:0] UV_SEL_RESET = 2'h3;
	// ------------------------------------------------------------
	// timing: accepted pulse widths in main-clock (fc) cycles
	// ------------------------------------------------------------
	localparam int NOISE_NARROW_CYCLES = 8;
	localparam int NOISE_WIDE_CYCLES = 32;
	localparam int NOISE_CNT_W = 6;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		SEL_NONE, SEL_ZERO, SEL_P5, SEL_P6, SEL_MODE, SEL_TIMER,
		SEL_RC, SEL_NOISE, SEL_OPT, SEL_GP
	} reg_sel_t;
	typedef enum logic [2:0] {
		PWR_RUN = 3'b001,
		PWR_IDLE = 3'b010,
		PWR_SLEEP = 3'b100
	} pwr_state_t;
	typedef struct packed {
		logic [3:0] trim;
		logic [1:0] range;
	} rc_cfg_t;
	typedef struct packed {
		logic [1:0] pkg_type;
		logic wide;
		logic enable;
		logic [1:0] uv_sel;
	} noise_uv_cfg_t;
endpackage
`default_nettype wire

// File: logic/int_noise_filter.sv
// external interrupt pin synchroniser, noise rejection and falling-edge detect
`default_nettype none
module int_noise_filter (
	input wire logic mclk,
	input wire logic srst,
	input wire logic int_pin,
	input wire logic filter_on,
	input wire logic wide,
	output logic fall_pulse
);
	// ------------------------------------------------------------
	// three-stage synchroniser
	// ------------------------------------------------------------
	logic sync1_reg;
	logic sync2_reg;
	logic sync3_reg;
	logic level_reg;
	logic [mode_sink_pkg::NOISE_CNT_W-1:0] cnt_reg;
	logic [mode_sink_pkg::NOISE_CNT_W-1:0] limit;
	logic agree;

	always_ff @(posedge mclk) begin
		if (srst) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			sync3_reg <= 1'b1;
		end else begin
			sync1_reg <= int_pin;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	assign agree = (sync2_reg == sync3_reg);
	assign limit = wide ? mode_sink_pkg::NOISE_CNT_W'(mode_sink_pkg::NOISE_WIDE_CYCLES - 1)
		: mode_sink_pkg::NOISE_CNT_W'(mode_sink_pkg::NOISE_NARROW_CYCLES - 1);

	// ------------------------------------------------------------
	// width qualification of the new level
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			level_reg <= 1'b1;
			cnt_reg <= '0;
			fall_pulse <= 1'b0;
		end else begin
			fall_pulse <= 1'b0;
			if (!agree || sync3_reg == level_reg) begin
				cnt_reg <= '0;
			end else if (!filter_on || cnt_reg >= limit) begin // see [R15]
				level_reg <= sync3_reg;
				cnt_reg <= '0;
				fall_pulse <= ~sync3_reg; // see [R16]
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: bench/mode_sink_bank_props.sv
// checker: port timing relations of the mode/sink register bank
`default_nettype none
module mode_sink_bank_props #(
	parameter bit EMULATOR = 1'b0
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sleep_instruction,
	input wire logic wake_event,
	input wire logic [7:0] port5_sink_control,
	input wire logic [7:0] port6_sink_control,
	input wire logic timer_clock_source_bit,
	input wire logic core_clock_select,
	input wire logic main_osc_run,
	input wire logic cpu_idle,
	input wire logic cpu_sleep,
	input wire logic watchdog_clear,
	input wire logic ext_int_event
);
	logic rd;
	logic wr;
	logic rsvd;
	logic [7:0] wbyte_reg;
	logic idle_reg;
	assign rd = psel && penable && pready && !pwrite;
	assign wr = psel && penable && pready && pwrite && pstrb[0];
	assign rsvd = (paddr[11:8] == 4'h2 && paddr[7:2] >= 6'h09 && paddr[7:2] <= 6'h0F)
		|| (paddr[11:8] == 4'h3 && paddr[7:2] >= 6'h08 && paddr[7:2] <= 6'h0F);
	always_ff @(posedge mclk) begin
		wbyte_reg <= pwdata[7:0];
	end
	// shadow of the idle choice bit
	always_ff @(posedge mclk) begin
		if (srst) begin
			idle_reg <= 1'b0;
		end else if (wr && paddr == 12'h220) begin
			idle_reg <= pwdata[4];
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	chk_p5_sink_write: assert property (wr && paddr == 12'h218 |=>
		port5_sink_control == wbyte_reg) else $error("port5 sink select not written");
	chk_p6_sink_write: assert property (wr && paddr == 12'h21C |=>
		port6_sink_control == wbyte_reg) else $error("port6 sink select not written");
	chk_mode_fixed_zero: assert property (rd && paddr == 12'h220 |->
		prdata[7] == 1'b0 && prdata[3:0] == 4'h0) else $error("mode unused bits not zero");
	chk_timer_src_write: assert property (wr && paddr == 12'h220 |=>
		timer_clock_source_bit == wbyte_reg[6]) else $error("timer source bit wrong");
	chk_core_clk_write: assert property (wr && paddr == 12'h220 |=>
		core_clock_select == wbyte_reg[5]) else $error("core clock select wrong");
	chk_main_osc_halt: assert property (!core_clock_select |-> !main_osc_run)
		else $error("main oscillator runs on sub clock");
	chk_sleep_mode_choice: assert property (sleep_instruction && !cpu_idle && !cpu_sleep
		&& !wake_event && !(wr && paddr == 12'h220) |=> cpu_idle == idle_reg
		&& cpu_sleep == !idle_reg) else $error("wrong low power state");
	chk_reserved_read_zero: assert property (rd && rsvd |->
		prdata == 32'h0000_0000 && !pslverr) else $error("reserved word not zero");
	chk_prod_trim_zero: assert property (!EMULATOR && rd &&
		(paddr == 12'h318 || paddr == 12'h31C) |-> prdata == 32'h0000_0000)
		else $error("trim register not zero on production part");
	chk_wdog_on_sleep: assert property ($rose(cpu_sleep) |-> ##[0:1] watchdog_clear)
		else $error("watchdog not cleared on sleep entry");
	cover property (wr && paddr == 12'h314);
	cover property ($rose(cpu_sleep));
	cover property ($rose(cpu_idle));
	cover property (ext_int_event);
endmodule
bind mode_sink_bank mode_sink_bank_props #(.EMULATOR(EMULATOR)) u_props (.mclk(mclk),
	.srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sleep_instruction(sleep_instruction), .wake_event(wake_event),
	.port5_sink_control(port5_sink_control), .port6_sink_control(port6_sink_control),
	.timer_clock_source_bit(timer_clock_source_bit), .core_clock_select(core_clock_select),
	.main_osc_run(main_osc_run), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
	.watchdog_clear(watchdog_clear), .ext_int_event(ext_int_event));
`default_nettype wire

// File: bench/test_mode_sink_bank.sv
// testbench: apb sequences against the mode/sink register bank
`default_nettype none
module test_mode_sink_bank;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, srst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic sleep_instruction, wake_event, instr_cycle_tick, sub_clock_tick, timer_pin;
	logic ext_int_pin, low_freq_crystal_mode, slow_crystal_mode_two;
	logic [7:0] port5_sink_control, port6_sink_control;
	logic timer_clock_source_bit, core_clock_select, main_osc_run, cpu_idle, cpu_sleep;
	logic watchdog_clear, ext_int_event;
	mode_sink_pkg::rc_cfg_t rc_cfg;
	mode_sink_pkg::noise_uv_cfg_t noise_uv_cfg;
	int err_total, checks, int_cnt, wd_cnt;
	mode_sink_bank #(.EMULATOR(1'b0)) uut (.mclk(mclk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleep_instruction(sleep_instruction), .wake_event(wake_event),
		.instr_cycle_tick(instr_cycle_tick), .sub_clock_tick(sub_clock_tick),
		.timer_pin(timer_pin), .ext_int_pin(ext_int_pin),
		.low_freq_crystal_mode(low_freq_crystal_mode),
		.slow_crystal_mode_two(slow_crystal_mode_two),
		.port5_sink_control(port5_sink_control), .port6_sink_control(port6_sink_control),
		.timer_clock_source_bit(timer_clock_source_bit), .core_clock_select(core_clock_select),
		.main_osc_run(main_osc_run), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
		.watchdog_clear(watchdog_clear), .ext_int_event(ext_int_event), .rc_cfg(rc_cfg),
		.noise_uv_cfg(noise_uv_cfg));
	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		if (ext_int_event === 1'b1) int_cnt++;
		if (watchdog_clear === 1'b1) wd_cnt++;
	end
	function automatic logic [11:0] adr(input logic [1:0] b, input logic [5:0] i);
		return {2'h0, b, i, 2'h0};
	endfunction
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask
	// ------------------------------------------------------------
	// apb master
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic s);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		pstrb <= {3'h0, s};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		check("pready", 32'h1, {31'h0, pready});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic apb_wr(input logic [11:0] a, input logic [7:0] d, input logic s);
		apb(1'b1, a, d, s);
		@(posedge mclk);
	endtask
	task automatic apb_rd(input logic [11:0] a, input logic [7:0] e, input logic er,
		input string n);
		apb(1'b0, a, 8'h00, 1'b0);
		check(n, {24'h00_0000, e}, prdata);
		check({n, " error"}, {31'h0, er}, {31'h0, pslverr});
	endtask
	task automatic tick(input logic i, input logic s);
		instr_cycle_tick <= i;
		sub_clock_tick <= s;
		@(posedge mclk);
		instr_cycle_tick <= 1'b0;
		sub_clock_tick <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic pin(input logic v);
		timer_pin <= v;
		repeat (5) @(posedge mclk);
	endtask
	task automatic step(input logic s, input logic w);
		sleep_instruction <= s;
		wake_event <= w;
		@(posedge mclk);
		sleep_instruction <= 1'b0;
		wake_event <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	task automatic int_low(input int n);
		ext_int_pin <= 1'b0;
		repeat (n) @(posedge mclk);
		ext_int_pin <= 1'b1;
		repeat (45) @(posedge mclk);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#200us;
		$display("[FAIL] watchdog expected finish seen hang");
		err_total++;
		results();
	end
	initial begin
		{mclk, psel, penable, pwrite, sleep_instruction, wake_event} = 6'h00;
		{instr_cycle_tick, sub_clock_tick, timer_pin} = 3'h0;
		{low_freq_crystal_mode, slow_crystal_mode_two} = 2'h0;
		{paddr, pwdata, pstrb} = '0;
		ext_int_pin = 1'b1;
		srst = 1'b1;
		{err_total, checks, int_cnt, wd_cnt} = '0;
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		apb_rd(adr(2, 6), 8'h00, 1'b0, "p5 reset");
		apb_rd(adr(2, 8), 8'h20, 1'b0, "mode reset");
		apb_rd(adr(3, 5), 8'h00, 1'b0, "timer reset");
		check("rc cfg", 32'h3F, {26'h0, rc_cfg});
		check("noise cfg", 32'h0F, {26'h0, noise_uv_cfg});
		$display("test reset done");
		apb_wr(adr(2, 6), 8'hA5, 1'b1);
		check("p5 pins", 32'hA5, {24'h0, port5_sink_control});
		apb_wr(adr(2, 7), 8'h81, 1'b1);
		apb_rd(adr(2, 7), 8'h81, 1'b0, "p6 read");
		apb_wr(adr(2, 6), 8'hFF, 1'b0);
		check("p5 no strobe", 32'hA5, {24'h0, port5_sink_control});
		$display("test sink done");
		apb_wr(adr(2, 8), 8'hFF, 1'b1);
		apb_rd(adr(2, 8), 8'h70, 1'b0, "mode mask");
		check("timer src", 32'h1, {31'h0, timer_clock_source_bit});
		apb_wr(adr(2, 8), 8'h00, 1'b1);
		check("core clk", 32'h0, {31'h0, core_clock_select});
		check("main osc", 32'h0, {31'h0, main_osc_run});
		$display("test mode done");
		for (int i = 8; i < 16; i++) begin
			apb_wr(adr(3, 6'(i)), 8'hFF, 1'b1);
			apb_rd(adr(3, 6'(i)), 8'h00, 1'b0, "bank3 reserved");
			if (i > 8) apb_wr(adr(2, 6'(i)), 8'hFF, 1'b1);
			if (i > 8) apb_rd(adr(2, 6'(i)), 8'h00, 1'b0, "bank2 reserved");
		end
		apb_wr(adr(3, 6), 8'hFF, 1'b1);
		apb_rd(adr(3, 6), 8'h00, 1'b0, "rc prod");
		apb_rd(adr(0, 0), 8'h00, 1'b1, "unmapped");
		apb_wr(adr(0, 16), 8'h5A, 1'b1);
		apb_rd(adr(3, 16), 8'h5A, 1'b0, "gp common");
		apb_wr(adr(0, 32), 8'h11, 1'b1);
		apb_wr(adr(1, 32), 8'h22, 1'b1);
		apb_wr(adr(3, 63), 8'hC3, 1'b1);
		apb_rd(adr(0, 32), 8'h11, 1'b0, "gp bank0");
		apb_rd(adr(1, 32), 8'h22, 1'b0, "gp bank1");
		apb_rd(adr(3, 63), 8'hC3, 1'b0, "gp last");
		$display("test map done");
		apb_wr(adr(3, 5), 8'h3C, 1'b1);
		apb_rd(adr(3, 5), 8'h3C, 1'b0, "timer rw");
		apb_wr(adr(0, 3), 8'h00, 1'b1);
		apb_wr(adr(2, 8), 8'h60, 1'b1);
		repeat (5) tick(1'b1, 1'b0);
		repeat (2) tick(1'b0, 1'b1);
		apb_rd(adr(3, 5), 8'h41, 1'b0, "timer main");
		apb_wr(adr(2, 8), 8'h20, 1'b1);
		repeat (3) tick(1'b0, 1'b1);
		repeat (2) tick(1'b1, 1'b0);
		apb_rd(adr(3, 5), 8'h44, 1'b0, "timer sub");
		apb_wr(adr(0, 3), 8'h20, 1'b1);
		repeat (2) begin
			pin(1'b1);
			pin(1'b0);
		end
		apb_rd(adr(3, 5), 8'h46, 1'b0, "timer rise");
		apb_wr(adr(0, 3), 8'h30, 1'b1);
		repeat (2) begin
			pin(1'b1);
			pin(1'b0);
		end
		apb_rd(adr(3, 5), 8'h48, 1'b0, "timer fall");
		$display("test timer done");
		apb_wr(adr(0, 3), 8'h00, 1'b1);
		apb_wr(adr(2, 8), 8'h60, 1'b1);
		step(1'b1, 1'b0);
		check("sleep", 32'h1, {31'h0, cpu_sleep});
		check("osc stop", 32'h0, {31'h0, main_osc_run});
		check("wdog clear", 32'h1, wd_cnt);
		repeat (3) tick(1'b1, 1'b0);
		step(1'b0, 1'b1);
		apb_rd(adr(3, 5), 8'h48, 1'b0, "timer asleep");
		apb_wr(adr(2, 8), 8'h70, 1'b1);
		step(1'b1, 1'b0);
		check("idle", 32'h1, {31'h0, cpu_idle});
		step(1'b0, 1'b1);
		check("run", 32'h0, {31'h0, cpu_idle});
		$display("test sleep done");
		int_low(10);
		check("glitch", 32'h0, int_cnt);
		int_low(45);
		check("wide fall", 32'h1, int_cnt);
		low_freq_crystal_mode <= 1'b1;
		int_low(4);
		check("lxt bypass", 32'h2, int_cnt);
		low_freq_crystal_mode <= 1'b0;
		slow_crystal_mode_two <= 1'b1;
		int_low(4);
		check("slow_crystal_mode_two bypass", 32'h3, int_cnt);
		$display("test interrupt done");
		results();
	end
endmodule
`default_nettype wire
